// >>> shared/urxb_pkg.sv
package urxb_pkg;
    // Register byte addresses
    localparam logic [3:0] URXB_ADDR_DATA = 4'h0;
    localparam logic [3:0] URXB_ADDR_STAT_A = 4'h4;
    localparam logic [3:0] URXB_ADDR_CTRL_B = 4'h8;
    localparam logic [3:0] URXB_ADDR_CTRL_C = 4'hC;
    // Status A bit positions
    localparam int URXB_BIT_RXC = 7;
    localparam int URXB_BIT_FE = 4;
    localparam int URXB_BIT_DOR = 3;
    localparam int URXB_BIT_PE = 2;
    // Control B bit positions
    localparam int URXB_BIT_IRQEN = 7;
    localparam int URXB_BIT_RECEIVER_ENABLE = 4;
    localparam int URXB_BIT_SZ2 = 2;
    localparam int URXB_BIT_RECEIVED_NINTH_BIT = 1;
    localparam int URXB_BIT_TRANSMIT_NINTH_BIT = 0;
    // Control C bit positions
    localparam int URXB_BIT_PARITY_ENABLE_BIT = 5;
    localparam int URXB_BIT_PARITY_ODD_SELECT = 4;
    localparam int URXB_BIT_STOP_BIT_COUNT_SELECT = 3;
    localparam int URXB_BIT_SZ1 = 2;
    localparam int URXB_BIT_SZ0 = 1;
    // Reset values and sizes
    localparam logic [7:0] URXB_CTRL_B_RST = 8'h00;
    localparam logic [7:0] URXB_CTRL_C_RST = 8'h06;
    localparam logic [2:0] URXB_SIZE_NINE = 3'h7;
    localparam int URXB_DEPTH = 2;
    localparam logic [3:0] URXB_BITS_BASE = 4'h5;
    // Receiver states
    typedef enum logic [2:0] {URXB_IDLE, URXB_DATA, URXB_PAR, URXB_STOP} urxb_state_t;
endpackage : urxb_pkg

// >>> verilog/urxb_receiver.sv
`timescale 1ns/1ps
// What this block does
// (R01) Setting receiver_enable turns receiver on and takes the serial input pin.
// (R02) Frame collection starts at a valid start bit; bits sampled on bit strobe.
// (R03) Only the first stop bit is examined; any second is ignored.
// (R04) After first stop bit the frame moves from shift register into buffer.
// (R05) Unused upper data bits read as zero for frames under eight bits.
// (R06) Software reads ninth bit and error flags before the low data byte.
// (R07) Reading data register advances FIFO; ninth bit and flags follow next entry.
// (R08) Receive-complete flag is one exactly while buffer holds unread data.
// (R09) Clearing receiver_enable flushes buffer and clears receive-complete flag.
// (R10) Interrupt request stays high while flag and enable and global enable set.
// (R11) Frame, overrun and parity flags are stored with their frame, read in status A.
// (R12) Software writes to the three error flag positions have no effect.
// (R13) Error flags never raise an interrupt request.
// (R14) Software writes zero to all flag positions of status A.
// (R15) Frame error is one when first stop bit sampled zero; stop count ignored.
// (R16) Overrun when start bit arrives, buffer full and shift register holds frame.
// (R17) Overrun clears when a frame transfers successfully into the buffer.
// (R18) With parity checking off the parity error flag reads zero.
// (R19) Parity computed over data bits, lower mode bit picks odd or even, compared.
// (R20) Parity error set only on mismatch while checking enabled; valid until read.
// (R21) Disabling the receiver is immediate and abandons the frame in progress.
// (R22) While disabled the serial input pin returns to its port function.
// (R23) Software flushes in normal use by reading data until flag reads zero.
// (R24) Lower parity-mode bit zero checks even parity, one checks odd.
module urxb_receiver
    import urxb_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Serial line, sampled once per strobe
    input wire logic rx_line,
    input wire logic bit_strobe,
    // Pin ownership and interrupt
    output logic pin_override,
    input wire logic global_irq_enable,
    output logic receive_complete_irq
);
    import urxb_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_s1_q;
    logic rst_n;
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    logic [7:0] ctrl_b_q;
    logic [7:0] ctrl_c_q;
    logic wb_req;
    logic wr_hit;
    logic rd_data;
    logic receiver_enable;
    logic [2:0] character_size_code;
    logic [3:0] nbits;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; // One answer per request
    assign wr_hit = wb_req && wb_we_i && wb_sel_i[0];
    assign rd_data = wb_req && !wb_we_i && (wb_adr_i == URXB_ADDR_DATA);
    assign receiver_enable = ctrl_b_q[URXB_BIT_RECEIVER_ENABLE];
    assign character_size_code = {ctrl_b_q[URXB_BIT_SZ2], ctrl_c_q[URXB_BIT_SZ1], ctrl_c_q[URXB_BIT_SZ0]};
    assign nbits = (character_size_code == URXB_SIZE_NINE) ? 4'h9
                 : (character_size_code[2] ? 4'h8 : URXB_BITS_BASE + {2'b00, character_size_code[1:0]});

    // Control B keeps the receive ninth bit read-only
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_b_q <= URXB_CTRL_B_RST;
        else if (wr_hit && wb_adr_i == URXB_ADDR_CTRL_B)
            ctrl_b_q <= wb_dat_i[7:0]; // see (R01) (R09) (R21)
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_c_q <= URXB_CTRL_C_RST;
        else if (wr_hit && wb_adr_i == URXB_ADDR_CTRL_C)
            ctrl_c_q <= wb_dat_i[7:0];
    end

    // Pin handed to receiver only while enabled
    assign pin_override = receiver_enable; // see (R01) (R22)

    ////////////////////////////////////////////////////////////////////////
    // Receive shifter
    urxb_state_t state_q;
    logic [8:0] shift_q;
    logic [3:0] cnt_q;
    logic par_err_q;
    logic pending_q;
    logic [8:0] pend_data_q;
    logic pend_fe_q;
    logic pend_pe_q;
    logic ovr_q;
    logic [1:0] count_q;
    logic buf_full;
    logic push;
    logic par_calc;

    assign buf_full = (count_q == 2'(URXB_DEPTH));
    // Even check with odd-select low, odd with it high
    assign par_calc = ^shift_q ^ ctrl_c_q[URXB_BIT_PARITY_ODD_SELECT]; // see (R19) (R24)

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= URXB_IDLE;
            shift_q <= 9'h000;
            cnt_q <= 4'h0;
            par_err_q <= 1'b0;
        end
        else if (!receiver_enable)
            state_q <= URXB_IDLE; // see (R21)
        else if (bit_strobe)
        begin
            case (state_q)
                URXB_IDLE:
                begin
                    if (!rx_line)
                    begin
                        state_q <= URXB_DATA; // see (R02)
                        shift_q <= 9'h000;
                        cnt_q <= 4'h0;
                    end
                end
                URXB_DATA:
                begin
                    shift_q[cnt_q] <= rx_line; // see (R02) (R05)
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q + 4'h1 == nbits)
                        state_q <= ctrl_c_q[URXB_BIT_PARITY_ENABLE_BIT] ? URXB_PAR : URXB_STOP;
                end
                URXB_PAR:
                begin
                    par_err_q <= par_calc ^ rx_line; // see (R19)
                    state_q <= URXB_STOP;
                end
                URXB_STOP:
                    state_q <= URXB_IDLE; // see (R03)
                default:
                    state_q <= URXB_IDLE;
            endcase
        end
    end

    // Completed frame waits here when buffer is full
    logic stop_done;
    assign stop_done = receiver_enable && bit_strobe && state_q == URXB_STOP;
    logic frame_pe;
    assign frame_pe = ctrl_c_q[URXB_BIT_PARITY_ENABLE_BIT] && par_err_q; // see (R18) (R20)

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pending_q <= 1'b0;
            pend_data_q <= 9'h000;
            pend_fe_q <= 1'b0;
            pend_pe_q <= 1'b0;
        end
        else if (!receiver_enable)
            pending_q <= 1'b0;
        else if (stop_done)
        begin
            pending_q <= 1'b1; // see (R04)
            pend_data_q <= shift_q;
            pend_fe_q <= !rx_line; // see (R15)
            pend_pe_q <= frame_pe;
        end
        else if (push)
            pending_q <= 1'b0;
    end

    // Overrun: start bit seen with buffer full and frame waiting
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ovr_q <= 1'b0;
        else if (!receiver_enable)
            ovr_q <= 1'b0;
        else if (bit_strobe && state_q == URXB_IDLE && !rx_line && pending_q && buf_full)
            ovr_q <= 1'b1; // see (R16)
        else if (push)
            ovr_q <= 1'b0; // see (R17)
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-entry receive buffer
    logic [11:0] fifo_q [URXB_DEPTH];
    logic rd_ptr_q;
    logic wr_ptr_q;
    logic pop;

    assign pop = rd_data && count_q != 2'h0; // see (R07)
    assign push = pending_q && (!buf_full || pop) && !(bit_strobe && state_q == URXB_IDLE && !rx_line && buf_full);

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_q <= 2'h0;
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
        end
        else if (!receiver_enable)
        begin
            count_q <= 2'h0; // see (R09)
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= !wr_ptr_q;
            if (pop)
                rd_ptr_q <= !rd_ptr_q; // see (R07)
            count_q <= count_q + 2'(push) - 2'(pop);
        end
    end

    // Entry: {fe, dor, pe, data9}; flags are held with their frame
    always_ff @(posedge sys_clk)
    begin
        if (push)
            fifo_q[wr_ptr_q] <= {pend_fe_q, ovr_q, pend_pe_q, pend_data_q}; // see (R11)
    end

    ////////////////////////////////////////////////////////////////////////
    // Read view and bus answer
    logic [11:0] head;
    logic receive_complete_flag;
    logic [7:0] data_mask;
    logic [7:0] rd_val;

    assign receive_complete_flag = count_q != 2'h0; // see (R08)
    assign head = receive_complete_flag ? fifo_q[rd_ptr_q] : 12'h000;
    assign data_mask = 8'hFF >> (4'h8 - ((nbits > 4'h8) ? 4'h8 : nbits));

    always_comb
    begin
        rd_val = 8'h00;
        case (wb_adr_i)
            URXB_ADDR_DATA: rd_val = head[7:0] & data_mask; // see (R05)
            URXB_ADDR_STAT_A:
            begin
                rd_val[URXB_BIT_RXC] = receive_complete_flag;
                rd_val[URXB_BIT_FE] = head[11]; // see (R11) (R12)
                rd_val[URXB_BIT_DOR] = head[10];
                rd_val[URXB_BIT_PE] = head[9];
            end
            URXB_ADDR_CTRL_B:
            begin
                rd_val = ctrl_b_q;
                rd_val[URXB_BIT_RECEIVED_NINTH_BIT] = head[8];
            end
            URXB_ADDR_CTRL_C: rd_val = ctrl_c_q;
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_req && wb_adr_i[1:0] == 2'h0;
            wb_err_o <= wb_req && wb_adr_i[1:0] != 2'h0;
            wb_dat_o <= {24'h000000, rd_val};
        end
    end

    // Only receive-complete drives the request
    assign receive_complete_irq = receive_complete_flag && ctrl_b_q[URXB_BIT_IRQEN] && global_irq_enable; // see (R10) (R13)

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Flag gone one edge after the enable falls
    chk_flush_empty: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (R09)
        $fell(receiver_enable) |=> !receive_complete_flag)
        else $error("buffer not flushed");
    // Pending frame and overrun dropped by the flush too
    chk_flush_all: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (R09)
        $fell(receiver_enable) |=> !pending_q && !ovr_q && count_q == 2'h0)
        else $error("flush incomplete");
    // Flag tracks the entry count
    chk_flag_count: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (R08)
        receive_complete_flag == (count_q != 2'h0))
        else $error("flag mismatch");
    // Request only while data is present
    chk_irq_follows: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (R10) (R13)
        receive_complete_irq |-> receive_complete_flag)
        else $error("irq without data");
    // Disabled receiver sits idle
    chk_abort_idle: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (R21)
        !receiver_enable |=> state_q == URXB_IDLE)
        else $error("frame not abandoned");
    // Low sample in idle opens a frame
    chk_start_frame: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (R02)
        receiver_enable && bit_strobe && state_q == URXB_IDLE && !rx_line |=> state_q == URXB_DATA)
        else $error("start bit missed");
    // First stop bit ends the frame
    chk_stop_idle: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (R03)
        stop_done |=> state_q == URXB_IDLE)
        else $error("frame not closed");
    // Completed frame waits for the buffer
    chk_push_frame: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (R04)
        stop_done |=> pending_q)
        else $error("frame not kept");
    // Frame error follows the first stop bit
    chk_fe_stored: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (R15)
        stop_done |=> pend_fe_q == !$past(rx_line))
        else $error("frame error wrong");
    // No parity error while checking is off
    chk_pe_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (R18)
        stop_done && !ctrl_c_q[URXB_BIT_PARITY_ENABLE_BIT] |=> !pend_pe_q)
        else $error("parity error while off");
    // Checked parity result kept with the frame
    chk_pe_stored: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (R20)
        stop_done && ctrl_c_q[URXB_BIT_PARITY_ENABLE_BIT] |=> pend_pe_q == $past(par_err_q))
        else $error("parity result lost");
    // Never more than two entries
    chk_no_overfill: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (R16)
        count_q <= 2'(URXB_DEPTH))
        else $error("buffer overfilled");
    // Start bit over a full buffer and a waiting frame
    chk_ovr_set: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (R16)
        receiver_enable && bit_strobe && state_q == URXB_IDLE && !rx_line && pending_q && buf_full |=> ovr_q)
        else $error("overrun missed");
    // Successful transfer clears overrun
    chk_ovr_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (R17)
        push && !stop_done |=> !ovr_q)
        else $error("overrun kept");
    // Data read moves the buffer on
    chk_pop_moves: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (R07)
        pop && !push |=> count_q == $past(count_q) - 2'h1)
        else $error("pop lost");
    // Receiver owns the pin exactly while enabled
    chk_pin_owner: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (R01) (R22)
        pin_override == receiver_enable)
        else $error("pin owner wrong");
    // Acknowledge lasts one cycle
    chk_ack_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    // Error answer lasts one cycle
    chk_err_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wb_err_o |=> !wb_err_o)
        else $error("err held");
endmodule : urxb_receiver

// >>> tb/urxb_serial_tx.sv
`timescale 1ns/1ps
// Remote transmitter driving the receive line
module urxb_serial_tx
(
    // Clock
    input wire logic sys_clk,
    // Serial side
    output logic rx_line,
    output logic bit_strobe
);
    logic [1:0] div_q = 2'h0;
    ////////////////////////////////////////////////////////////////
    // Free-running bit strobe, one clock in four
    always @(posedge sys_clk)
    begin
        div_q <= div_q + 2'h1;
    end
    assign bit_strobe = (div_q == 2'h3);
    // Line idles at mark level
    initial rx_line = 1'b1;
    ////////////////////////////////////////////////////////////////
    // One bit held from strobe to strobe
    task automatic put(input logic b);
        @(posedge sys_clk iff bit_strobe);
        rx_line <= b;
    endtask : put
    // Start, data LSB first, optional parity, stop, then idle
    task automatic frame(input logic [8:0] d, input int nb, input bit pen, input logic pb, input logic stp);
        put(1'b0);
        for (int i = 0; i < nb; i++)
        begin
            put(d[i]);
        end
        if (pen)
        begin
            put(pb);
        end
        put(stp);
        put(1'b1); // Second stop bit, never examined
        put(1'b1);
    endtask : frame
endmodule : urxb_serial_tx

// >>> tb/urxb_receiver_bench.sv
`timescale 1ns/1ps
// Register-level tests of the receive buffer and its flags
module urxb_receiver_bench;
    import urxb_pkg::*;
    logic sys_clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
    logic [3:0] wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic rx_line, bit_strobe, pin_override, global_irq_enable, receive_complete_irq;
    logic bus_err;
    logic [31:0] spare_rd;
    int n_mismatch = 0;
    int checks_done = 0;
    ////////////////////////////////////////////////////////////////
    // Design and remote transmitter
    urxb_receiver i_urxb_receiver (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .rx_line(rx_line), .bit_strobe(bit_strobe), .pin_override(pin_override),
        .global_irq_enable(global_irq_enable), .receive_complete_irq(receive_complete_irq));
    urxb_serial_tx i_urxb_serial_tx (.sys_clk(sys_clk), .rx_line(rx_line), .bit_strobe(bit_strobe));
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////
    // Compare, bus cycle and helper tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic xfer(input logic we, input logic [3:0] adr, input logic [7:0] wd, output logic [31:0] rd);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h000000, wd};
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1)
        begin
            @(posedge sys_clk);
        end
        rd = wb_dat_o;
        bus_err = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [3:0] adr, input logic [7:0] wd);
        logic [31:0] rd;
        xfer(1'b1, adr, wd, rd);
    endtask : wr
    task automatic rc(input string what, input logic [3:0] adr, input logic [7:0] exp);
        logic [31:0] rd;
        xfer(1'b0, adr, 8'h00, rd);
        chk(what, {24'h000000, exp}, rd);
    endtask : rc
    task automatic tx(input logic [8:0] d, input int nb, input bit pen, input logic pb, input logic stp);
        i_urxb_serial_tx.frame(d, nb, pen, pb, stp);
    endtask : tx
    task automatic pin_irq(input logic g, input logic ep, input logic ei);
        @(posedge sys_clk);
        global_irq_enable <= g;
        @(negedge sys_clk);
        chk("pin", {31'h0, ep}, {31'h0, pin_override});
        chk("irq", {31'h0, ei}, {31'h0, receive_complete_irq});
    endtask : pin_irq
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////
    // Hang guard
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////
    // Test sequence
    initial
    begin
        {resetn, wb_cyc_i, wb_stb_i, wb_we_i, global_irq_enable} = 5'h00;
        wb_adr_i = 4'h0;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rc("ctrl_c", URXB_ADDR_CTRL_C, URXB_CTRL_C_RST);
        rc("ctrl_b", URXB_ADDR_CTRL_B, URXB_CTRL_B_RST);
        pin_irq(1'b1, 1'b0, 1'b0);
        wr(URXB_ADDR_CTRL_B, 8'h90);
        tx(9'h0A5, 8, 1'b0, 1'b0, 1'b1);
        pin_irq(1'b1, 1'b1, 1'b1);
        pin_irq(1'b0, 1'b1, 1'b0);
        rc("status", URXB_ADDR_STAT_A, 8'h80);
        rc("data", URXB_ADDR_DATA, 8'hA5);
        pin_irq(1'b1, 1'b1, 1'b0);
        xfer(1'b0, 4'h6, 8'h00, spare_rd);
        chk("bus err", 32'h0000_0001, {31'h0, bus_err});
        rc("status", URXB_ADDR_STAT_A, 8'h00);
        chk("bus ok", 32'h0000_0000, {31'h0, bus_err});
        $display("test basic done");
        for (int m = 0; m < 2; m++)
        begin
            wr(URXB_ADDR_CTRL_C, m ? 8'h36 : 8'h26);
            tx(9'h003, 8, 1'b1, 1'(m), 1'b1);
            tx(9'h003, 8, 1'b1, 1'(1 - m), 1'b1);
            rc("par ok", URXB_ADDR_STAT_A, 8'h80);
            rc("data", URXB_ADDR_DATA, 8'h03);
            rc("par bad", URXB_ADDR_STAT_A, 8'h84);
            rc("data", URXB_ADDR_DATA, 8'h03);
            rc("empty", URXB_ADDR_STAT_A, 8'h00);
        end
        $display("test parity done");
        wr(URXB_ADDR_CTRL_C, 8'h0E);
        tx(9'h05A, 8, 1'b0, 1'b0, 1'b0);
        wr(URXB_ADDR_STAT_A, 8'h00);
        rc("frame err", URXB_ADDR_STAT_A, 8'h90);
        rc("data", URXB_ADDR_DATA, 8'h5A);
        wr(URXB_ADDR_CTRL_C, 8'h00);
        tx(9'h1FF, 5, 1'b0, 1'b0, 1'b1);
        rc("short", URXB_ADDR_DATA, 8'h1F);
        wr(URXB_ADDR_CTRL_C, 8'h06);
        wr(URXB_ADDR_CTRL_B, 8'h14);
        tx(9'h1A5, 9, 1'b0, 1'b0, 1'b1);
        rc("ninth", URXB_ADDR_CTRL_B, 8'h16);
        rc("status", URXB_ADDR_STAT_A, 8'h80);
        rc("low byte", URXB_ADDR_DATA, 8'hA5);
        $display("test format done");
        wr(URXB_ADDR_CTRL_B, 8'h90);
        for (int k = 1; k < 5; k++)
        begin
            tx(9'(k), 8, 1'b0, 1'b0, 1'b1);
        end
        rc("status", URXB_ADDR_STAT_A, 8'h80);
        rc("data", URXB_ADDR_DATA, 8'h01);
        rc("status", URXB_ADDR_STAT_A, 8'h80);
        rc("data", URXB_ADDR_DATA, 8'h02);
        rc("overrun", URXB_ADDR_STAT_A, 8'h88);
        rc("data", URXB_ADDR_DATA, 8'h04);
        $display("test overrun done");
        tx(9'h066, 8, 1'b0, 1'b0, 1'b1);
        fork
            tx(9'h000, 8, 1'b0, 1'b0, 1'b1);
        join_none
        repeat (12) @(posedge sys_clk);
        wr(URXB_ADDR_CTRL_B, 8'h80);
        pin_irq(1'b1, 1'b0, 1'b0);
        wait fork;
        wr(URXB_ADDR_CTRL_B, 8'h90);
        rc("flushed", URXB_ADDR_STAT_A, 8'h00);
        tx(9'h03C, 8, 1'b0, 1'b0, 1'b1);
        rc("clean", URXB_ADDR_STAT_A, 8'h80);
        rc("data", URXB_ADDR_DATA, 8'h3C);
        rc("empty", URXB_ADDR_STAT_A, 8'h00);
        $display("test flush done");
        summarize();
    end
endmodule : urxb_receiver_bench
